/* File: design/dc_balanced_video_serializer.sv */
// dc balanced parallel to serial transmitter for display links
`timescale 1ns/1ns
module dc_balanced_video_serializer #(
    parameter int LOCK_CYCLES = video_ser_pkg::LOCK_PCLK_CYCLES
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // parallel pins
    input  wire logic        pclk_in,
    input  wire logic [17:0] video_data_in,
    input  wire logic [8:0]  control_data_in,
    input  wire logic        data_enable_in,
    // power and range pins
    input  wire logic        power_down_n,
    input  wire logic        range_select_lo,
    input  wire logic        range_select_hi,
    // serial line
    output logic             serial_out,
    output logic             serial_oe_n,
    // word port to the fast serial stage
    output logic [19:0]      serial_word,
    output logic             word_load,
    // status
    output logic             pll_locked,
    output logic             pclk_out_of_range,
    output logic [1:0]       range_band
);

    localparam int SYNC_W = 1 + video_ser_pkg::VID_W + video_ser_pkg::CTL_W + 4;
    // all pins pass two flops before use
    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_s;
    assign pins_raw = {pclk_in, video_data_in, control_data_in, data_enable_in,
                       power_down_n, range_select_hi, range_select_lo};

    pin_sync #(
        .W (SYNC_W)
    ) u_sync (
        .mclk     (mclk),
        .arst_n   (arst_n),
        .pin_in   (pins_raw),
        .sync_out (pins_s)
    );

    logic        pclk_s;
    logic [17:0] vid_s;
    logic [8:0]  ctl_s;
    logic        de_s;
    logic        pwr_s;
    logic [1:0]  rng_s;

    assign pclk_s = pins_s[SYNC_W-1];
    assign vid_s  = pins_s[SYNC_W-2 -: video_ser_pkg::VID_W];
    assign ctl_s  = pins_s[4 + video_ser_pkg::CTL_W - 1 -: video_ser_pkg::CTL_W];
    assign de_s   = pins_s[3];
    assign pwr_s  = pins_s[2];
    assign rng_s  = pins_s[1:0];

    // ones count of a serial word
    function automatic logic [4:0] ones(input logic [19:0] w);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < video_ser_pkg::WORD_W; i++) begin
            n = n + 5'(w[i]);
        end
        return n;
    endfunction

    // word disparity: ones minus zeros
    function automatic logic signed [7:0] disp(input logic [19:0] w);
        return $signed({3'h0, ones(w)}) * 8'sh02 - 8'sh14;
    endfunction

    // control mapping: triples for bits 0-4, singles for bits 5-8
    function automatic logic [19:0] ctl_word(input logic [8:0] c);
        logic [19:0] w;
        w = 20'h00000;
        w[video_ser_pkg::FLAG0_POS] = 1'b1;
        for (int i = 0; i < video_ser_pkg::CTL_TRIPLE_N; i++) begin
            for (int k = 0; k < video_ser_pkg::CTL_REPL; k++) begin
                w[video_ser_pkg::CTL_TRIPLE_BASE + i*video_ser_pkg::CTL_REPL + k] = c[i];
            end
        end
        for (int i = video_ser_pkg::CTL_TRIPLE_N; i < video_ser_pkg::CTL_W; i++) begin
            w[video_ser_pkg::CTL_SINGLE_BASE + i - video_ser_pkg::CTL_TRIPLE_N] = c[i];
        end
        return w;
    endfunction

    // parallel clock edge and period check
    logic             pclk_d_ff;
    logic             nxt_pclk_d;
    logic             pclk_rise;
    logic [7:0]       per_cnt_ff;
    logic [7:0]       nxt_per_cnt;
    logic             oor_ff;
    logic             nxt_oor;
    logic [1:0]       band_ff;
    logic [1:0]       nxt_band;
    assign pclk_rise = pclk_s & ~pclk_d_ff;
    always_comb begin
        nxt_pclk_d  = pclk_s;
        nxt_per_cnt = per_cnt_ff;
        nxt_oor     = oor_ff;
        nxt_band    = rng_s;
        if (pclk_rise) begin
            nxt_per_cnt = 8'h01;
            nxt_oor     = (per_cnt_ff < video_ser_pkg::PCLK_PER_MIN);
        end else if (per_cnt_ff != 8'hff) begin
            nxt_per_cnt = per_cnt_ff + 8'h01;
        end
        // a stalled clock is flagged without waiting for the next edge
        if (per_cnt_ff > video_ser_pkg::PCLK_PER_MAX) begin
            nxt_oor = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pclk_d_ff  <= 1'b0;
            per_cnt_ff <= 8'h00;
            oor_ff     <= 1'b0;
            band_ff    <= 2'h0;
        end else begin
            pclk_d_ff  <= nxt_pclk_d;
            per_cnt_ff <= nxt_per_cnt;
            oor_ff     <= nxt_oor;
            band_ff    <= nxt_band;
        end
    end

    // power down and lock wait
    logic [14:0] lock_cnt_ff;
    logic [14:0] nxt_lock_cnt;
    logic        locked_ff;
    logic        nxt_locked;
    always_comb begin
        nxt_lock_cnt = lock_cnt_ff;
        nxt_locked   = locked_ff;
        if (!pwr_s) begin
            nxt_lock_cnt = 15'h0000;
            nxt_locked   = 1'b0;
        end else if (!locked_ff && pclk_rise) begin
            if (lock_cnt_ff == 15'(LOCK_CYCLES - 1)) begin
                nxt_locked = 1'b1;
            end else begin
                nxt_lock_cnt = lock_cnt_ff + 15'h0001;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            lock_cnt_ff <= 15'h0000;
            locked_ff   <= 1'b0;
        end else begin
            lock_cnt_ff <= nxt_lock_cnt;
            locked_ff   <= nxt_locked;
        end
    end

    // capture pipeline: three stages so a rising enable is seen two cycles early
    logic [2:0]  st_de_ff;
    logic [2:0]  nxt_st_de;
    logic [17:0] st_dat_ff  [video_ser_pkg::STAGES];
    logic [17:0] nxt_st_dat [video_ser_pkg::STAGES];
    logic [1:0]  hist_de_ff;
    logic [1:0]  nxt_hist_de;
    always_comb begin
        nxt_st_de   = st_de_ff;
        nxt_hist_de = hist_de_ff;
        for (int i = 0; i < video_ser_pkg::STAGES; i++) begin
            nxt_st_dat[i] = st_dat_ff[i];
        end
        if (!pwr_s) begin
            nxt_st_de   = 3'h0;
            nxt_hist_de = 2'h0;
        end else if (pclk_rise) begin
            nxt_st_de = {st_de_ff[1:0], de_s};
            if (de_s) begin
                nxt_st_dat[0] = vid_s;
            end else begin
                // control taken here is dropped later if it falls in a blanked window
                nxt_st_dat[0] = {9'h000, ctl_s};
            end
            for (int i = 1; i < video_ser_pkg::STAGES; i++) begin
                nxt_st_dat[i] = st_dat_ff[i-1];
            end
            nxt_hist_de = {hist_de_ff[0], st_de_ff[2]};
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_de_ff   <= 3'h0;
            hist_de_ff <= 2'h0;
            for (int i = 0; i < video_ser_pkg::STAGES; i++) begin
                st_dat_ff[i] <= 18'h00000;
            end
        end else begin
            st_de_ff   <= nxt_st_de;
            hist_de_ff <= nxt_hist_de;
            for (int i = 0; i < video_ser_pkg::STAGES; i++) begin
                st_dat_ff[i] <= nxt_st_dat[i];
            end
        end
    end

    // word selection and encoding
    video_ser_pkg::out_kind_t kind;
    logic [19:0]              vid_plain;
    logic [19:0]              vid_word;
    logic [19:0]              ctl_w;
    logic signed [7:0]        vid_disp;
    logic                     vid_inv;
    always_comb begin
        if (st_de_ff[2]) begin
            kind = video_ser_pkg::OUT_VIDEO;
        end else if (st_de_ff[1] | st_de_ff[0]) begin
            kind = video_ser_pkg::OUT_TRANS;
        end else if (hist_de_ff[0] | hist_de_ff[1]) begin
            kind = video_ser_pkg::OUT_TRANS;
        end else begin
            kind = video_ser_pkg::OUT_CONTROL;
        end
    end

    logic signed [7:0] rd_ff;
    logic signed [7:0] nxt_rd;
    always_comb begin
        vid_plain = {st_dat_ff[2], 2'b10};
        vid_disp  = disp(vid_plain);
        // invert when the word would push disparity further the same way
        vid_inv   = ((rd_ff > video_ser_pkg::DISP_ZERO) && (vid_disp > video_ser_pkg::DISP_ZERO))
                 || ((rd_ff < video_ser_pkg::DISP_ZERO) && (vid_disp < video_ser_pkg::DISP_ZERO));
        vid_word  = vid_inv ? {~st_dat_ff[2], 2'b01} : vid_plain;
        ctl_w     = ctl_word(st_dat_ff[2][8:0]);
    end

    logic [19:0] word_ff;
    logic [19:0] nxt_word;
    logic        load_ff;
    logic        nxt_load;
    always_comb begin
        nxt_word = word_ff;
        nxt_rd   = rd_ff;
        nxt_load = 1'b0;
        if (!pwr_s) begin
            nxt_rd = video_ser_pkg::DISP_ZERO;
        end else if (pclk_rise) begin
            nxt_load = 1'b1;
            case (kind)
                video_ser_pkg::OUT_VIDEO:   nxt_word = vid_word;
                video_ser_pkg::OUT_CONTROL: nxt_word = ctl_w;
                video_ser_pkg::OUT_TRANS:   nxt_word = video_ser_pkg::TRANS_WORD;
                default:                    nxt_word = word_ff;
            endcase
            nxt_rd = rd_ff + disp(nxt_word);
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            word_ff <= 20'h00000;
            rd_ff   <= video_ser_pkg::DISP_ZERO;
            load_ff <= 1'b0;
        end else begin
            word_ff <= nxt_word;
            rd_ff   <= nxt_rd;
            load_ff <= nxt_load;
        end
    end

    // bit shifter; the full 20 bits fit only while the pclk period is >= 20 mclk
    logic [19:0] shift_ff;
    logic [19:0] nxt_shift;
    logic        bit_ff;
    logic        nxt_bit;
    logic        oe_n_ff;
    logic        nxt_oe_n;
    always_comb begin
        nxt_oe_n  = ~(pwr_s & locked_ff);
        if (load_ff) begin
            nxt_bit   = word_ff[0];
            nxt_shift = {1'b0, word_ff[19:1]};
        end else begin
            nxt_bit   = shift_ff[0];
            nxt_shift = {1'b0, shift_ff[19:1]};
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            shift_ff <= 20'h00000;
            bit_ff   <= 1'b0;
            oe_n_ff  <= 1'b1;
        end else begin
            shift_ff <= nxt_shift;
            bit_ff   <= nxt_bit;
            oe_n_ff  <= nxt_oe_n;
        end
    end

    assign serial_out        = bit_ff;
    assign serial_oe_n       = oe_n_ff;
    assign serial_word       = word_ff;
    assign word_load         = load_ff;
    assign pll_locked        = locked_ff;
    assign pclk_out_of_range = oor_ff;
    assign range_band        = band_ff;

endmodule

/* File: design/video_ser_pkg.sv */
// constants, types and word layout for the dc balanced video serializer
package video_ser_pkg;

    // parallel widths
    localparam int VID_W        = 18;
    localparam int CTL_W        = 9;
    localparam int WORD_W       = 20;
    localparam int CNT_W        = 5;

    // video word layout
    localparam int FLAG0_POS    = 0;
    localparam int FLAG1_POS    = 1;
    localparam int VID_SYM_BASE = 2;

    // control word layout
    localparam int CTL_TRIPLE_N    = 5;
    localparam int CTL_REPL        = 3;
    localparam int CTL_TRIPLE_BASE = 1;
    localparam int CTL_SINGLE_BASE = 16;

    // transition words: bits 1:0 are 00, which no video or control word carries
    localparam logic [19:0] TRANS_WORD = 20'h55554;
    localparam int          TRANS_LEN  = 2;

    // pipeline depth needed to see data enable rise two cycles ahead
    localparam int STAGES = 3;

    // lock wait in parallel clock cycles
    localparam int LOCK_PCLK_CYCLES = 16385;
    localparam int LOCK_W           = 15;

    // clock rates
    localparam int MCLK_MHZ     = 250;
    localparam int PCLK_MIN_MHZ = 3;
    localparam int PCLK_MAX_MHZ = 35;
    localparam int PER_W        = 8;
    // shortest legal period rounds down, longest rounds up
    localparam logic [7:0] PCLK_PER_MIN = 8'(MCLK_MHZ / PCLK_MAX_MHZ);
    localparam logic [7:0] PCLK_PER_MAX = 8'((MCLK_MHZ + PCLK_MIN_MHZ - 1) / PCLK_MIN_MHZ);

    // disparity accumulator
    localparam int DISP_W = 8;
    localparam logic signed [7:0] DISP_ZERO = 8'sh00;

    typedef enum logic [1:0] {
        OUT_IDLE,
        OUT_VIDEO,
        OUT_CONTROL,
        OUT_TRANS
    } out_kind_t;

endpackage

/* File: design/pin_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         arst_n,
    // pins in, synced out
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_sync;

    always_comb begin
        nxt_meta = pin_in;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign sync_out = sync_ff;

endmodule

/* File: bench/ser_monitor.sv */
// port checker for the serializer, bound into the design
`timescale 1ns/1ns
module ser_monitor (
    // clock and reset
    input wire logic        mclk,
    input wire logic        arst_n,
    // pins
    input wire logic        pclk_in,
    input wire logic        power_down_n,
    input wire logic        range_select_lo,
    input wire logic        range_select_hi,
    // outputs
    input wire logic        serial_out,
    input wire logic        serial_oe_n,
    input wire logic [19:0] serial_word,
    input wire logic        word_load,
    input wire logic        pll_locked,
    input wire logic [1:0]  range_band
);
    wire logic [1:0] band_pins = {range_select_hi, range_select_lo};
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    // sync plus one edge, so four low cycles are surely seen
    sequence pd_held;
        !power_down_n [*4];
    endsequence
    sequence first_bits;
        ##1 serial_out == $past(serial_word[0]) ##1 serial_out == $past(serial_word[1], 2);
    endsequence
    sequence last_bit;
        ##20 serial_out == $past(serial_word[19], 20);
    endsequence
    // powered long enough that the pipeline is no longer held
    sequence pclk_rise_up;
        $rose(pclk_in) && power_down_n && $past(power_down_n, 8);
    endsequence
    chk_pd_float: assert property (pd_held |-> serial_oe_n)
        else $error("serial output driven in power down");
    chk_pd_unlock: assert property (pd_held |-> !pll_locked)
        else $error("lock held in power down");
    chk_lock_first: assert property (!pll_locked |-> serial_oe_n)
        else $error("serial output driven before lock");
    chk_lsb_first: assert property (word_load && !serial_oe_n |-> first_bits)
        else $error("first bits not sent lsb first");
    chk_last_bit: assert property (word_load && !serial_oe_n |-> last_bit)
        else $error("bit 19 not sent twentieth");
    chk_load_cause: assert property (pclk_rise_up |-> ##[2:6] word_load)
        else $error("no word loaded after parallel clock rise");
    chk_load_once: assert property (word_load |=> !word_load)
        else $error("word load longer than one cycle");
    chk_word_held: assert property ($changed(serial_word) && power_down_n
        && $past(power_down_n, 4) |-> word_load)
        else $error("serial word changed without load");
    chk_trans_unique: assert property (word_load && serial_word[1:0] == 2'h0
        |-> serial_word == video_ser_pkg::TRANS_WORD)
        else $error("flags 00 on a non transition word");
    chk_c0_triple: assert property (word_load && serial_word[1:0] == 2'h3
        |-> serial_word[3:2] == 2'h3)
        else $error("control bit zero copies differ");
    chk_band_copy: assert property ($stable(band_pins) [*5] |-> range_band == band_pins)
        else $error("range band not following pins");
endmodule

bind dc_balanced_video_serializer ser_monitor ser_monitor_i (
    .mclk, .arst_n, .pclk_in, .power_down_n, .range_select_lo, .range_select_hi,
    .serial_out, .serial_oe_n, .serial_word, .word_load, .pll_locked, .range_band
);

/* File: bench/deser_model.sv */
// receiver model that decodes each loaded word
`timescale 1ns/1ns
module deser_model (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // words from the serializer
    input  wire logic [19:0] serial_word,
    input  wire logic        word_load,
    // recovered values
    output logic      [17:0] vid_q,
    output logic      [8:0]  ctl_q,
    output logic      [3:0]  ntr
);
    logic       vid_ph;
    logic       ph;
    logic [3:0] run;
    function automatic logic maj(input logic [2:0] t);
        return (t[0] & t[1]) | (t[0] & t[2]) | (t[1] & t[2]);
    endfunction
    // phase is known only from transition runs, as on the real link
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            vid_q <= 18'h0;
            ctl_q <= 9'h0;
            ntr <= 4'h0;
            run <= 4'h0;
            vid_ph <= 1'b0;
        end else if (word_load) begin
            ph = (run != 4'h0) ? !vid_ph : vid_ph;
            if (serial_word == video_ser_pkg::TRANS_WORD) begin
                run <= run + 4'h1;
            end else begin
                if (run != 4'h0) begin
                    ntr <= run;
                end
                run <= 4'h0;
                vid_ph <= ph;
                if (ph) begin
                    vid_q <= (serial_word[1:0] == 2'h1) ? ~serial_word[19:2] : serial_word[19:2];
                end else begin
                    for (int i = 0; i < 5; i++) begin
                        ctl_q[i] <= maj(serial_word[3*i+1 +: 3]);
                    end
                    ctl_q[8:5] <= serial_word[19:16];
                end
            end
        end
    end
endmodule

/* File: bench/tb_dc_balanced_video_serializer.sv */
// self-checking bench for the dc balanced video serializer
`timescale 1ns/1ns
module tb_dc_balanced_video_serializer;
    // short lock wait keeps the run brief
    localparam int LOCK = 8;
    logic        mclk, arst_n, pclk_in, data_enable_in, power_down_n;
    logic        range_select_lo, range_select_hi, serial_out, serial_oe_n;
    logic        word_load, pll_locked, pclk_out_of_range;
    logic [17:0] video_data_in, vid_q;
    logic [8:0]  control_data_in, ctl_q;
    logic [19:0] serial_word;
    logic [1:0]  range_band;
    logic [3:0]  ntr;
    int          failures, checked;

    dc_balanced_video_serializer #(.LOCK_CYCLES(LOCK)) dc_balanced_video_serializer_i (
        .mclk, .arst_n, .pclk_in, .video_data_in, .control_data_in, .data_enable_in,
        .power_down_n, .range_select_lo, .range_select_hi, .serial_out, .serial_oe_n,
        .serial_word, .word_load, .pll_locked, .pclk_out_of_range, .range_band);
    deser_model deser_model_i (
        .mclk, .arst_n, .serial_word, .word_load, .vid_q, .ctl_q, .ntr);

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic cmp_val(input logic [19:0] got, input logic [19:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        if (failures == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // one parallel cycle of 24 mclk; pins change while the clock is low
    task automatic pcyc(input logic de, input logic [17:0] v, input logic [8:0] c);
        @(posedge mclk);
        pclk_in <= 1'b0;
        data_enable_in <= de;
        video_data_in <= v;
        control_data_in <= c;
        repeat (12) @(posedge mclk);
        pclk_in <= 1'b1;
        repeat (11) @(posedge mclk);
    endtask

    function automatic logic [19:0] ctl_word(input logic [8:0] c);
        logic [19:0] w;
        w = {c[8:5], 16'h0001};
        for (int i = 0; i < 5; i++) begin
            w[3*i+1 +: 3] = {3{c[i]}};
        end
        return w;
    endfunction

    task automatic s_lock();
        power_down_n <= 1'b1;
        repeat (LOCK - 1) pcyc(1'b0, 18'h0, 9'h0);
        cmp_val(20'(pll_locked), 20'h0);
        cmp_val(20'(serial_oe_n), 20'h1);
        pcyc(1'b0, 18'h0, 9'h0);
        cmp_val(20'(pll_locked), 20'h1);
        cmp_val(20'(serial_oe_n), 20'h0);
    endtask

    task automatic s_ctrl();
        logic [8:0] c [5] = '{9'h000, 9'h1ff, 9'h155, 9'h0aa, 9'h121};
        // three pclk cycles of latency, so four samples of each value
        for (int k = 0; k < 5; k++) begin
            repeat (4) pcyc(1'b0, 18'h0, c[k]);
            cmp_val(serial_word, ctl_word(c[k]));
            cmp_val(20'(ctl_q), 20'(c[k]));
        end
    endtask

    // equal video words back to back force the inverted form
    task automatic s_phases();
        logic [17:0] v [4] = '{18'h3ffff, 18'h3ffff, 18'h2aaaa, 18'h00f0f};
        repeat (3) pcyc(1'b0, 18'h0, 9'h0a5);
        repeat (2) pcyc(1'b0, 18'h0, 9'h15a);
        for (int k = 0; k < 4; k++) begin
            pcyc(1'b1, v[k], 9'h1c3);
            if (k >= 1) cmp_val(20'(ctl_q), 20'h0a5);
            if (k == 3) cmp_val(20'(vid_q), 20'(v[0]));
        end
        cmp_val(20'(ntr), 20'h2);
        for (int k = 0; k < 6; k++) begin
            pcyc(1'b0, 18'h0, (k < 2) ? 9'h03c : 9'h0e7);
            if (k < 3) cmp_val(20'(vid_q), 20'(v[k+1]));
            if (k >= 3 && k < 5) cmp_val(20'(ctl_q), 20'h0a5);
        end
        cmp_val(20'(vid_q), 20'(v[3]));
        cmp_val(20'(ctl_q), 20'h0e7);
        cmp_val(20'(ntr), 20'h2);
    endtask

    task automatic s_range();
        for (int b = 0; b < 4; b++) begin
            @(posedge mclk);
            {range_select_hi, range_select_lo} <= 2'(b);
            repeat (6) @(posedge mclk);
            cmp_val(20'(range_band), 20'(b));
        end
    endtask

    task automatic s_pd();
        power_down_n <= 1'b0;
        repeat (6) @(posedge mclk);
        cmp_val(20'(serial_oe_n), 20'h1);
        cmp_val(20'(pll_locked), 20'h0);
        s_lock();
    endtask

    task automatic s_slow();
        repeat (100) @(posedge mclk);
        cmp_val(20'(pclk_out_of_range), 20'h1);
        repeat (2) pcyc(1'b0, 18'h0, 9'h0);
        cmp_val(20'(pclk_out_of_range), 20'h0);
    endtask

    initial begin
        repeat (30000) @(posedge mclk);
        failures++;
        stop_test();
    end

    initial begin
        arst_n = 1'b0;
        pclk_in = 1'b0;
        video_data_in = 18'h0;
        control_data_in = 9'h0;
        data_enable_in = 1'b0;
        power_down_n = 1'b0;
        range_select_lo = 1'b0;
        range_select_hi = 1'b0;
        failures = 0;
        checked = 0;
        repeat (10) @(posedge mclk);
        arst_n <= 1'b1;
        s_lock();
        s_ctrl();
        s_phases();
        s_range();
        s_pd();
        s_slow();
        stop_test();
    end
endmodule
